// ===== core/vwr_cfg.svh
// Constants of the VRAM wait and row-strobe timing block.
// Assumes inclusion by bare name from the core/ files.
`ifndef VWR_CFG_SVH
`define VWR_CFG_SVH

// Register offsets on the plain register port
`define VWR_OFS_PROG 4'h0
`define VWR_OFS_STAT 4'h4

// Programming word after reset
`define VWR_PROG_RST 11'h000

// Status word layout
`define VWR_STAT_STATE 0
`define VWR_STAT_READY 5
`define VWR_STAT_GRANT 6
`define VWR_STAT_INIT  7

// Refresh row-strobe width in rising edges, per row-timing code
`define VWR_REFW_00 3'h2
`define VWR_REFW_01 3'h3
`define VWR_REFW_10 3'h2
`define VWR_REFW_11 3'h4

// Precharge time in rising edges, per row-timing code
`define VWR_PRE_00 3'h1
`define VWR_PRE_01 3'h2
`define VWR_PRE_10 3'h2
`define VWR_PRE_11 3'h3

// Row-strobe start after a grant change, in rising edges
`define VWR_GNT_00 3'h1
`define VWR_GNT_01 3'h2
`define VWR_GNT_10 3'h1
`define VWR_GNT_11 3'h2

// Handshake delays, in rising edges after the row-strobe edge
`define VWR_ZERO_T    3'h0
`define VWR_HALF_T    3'h1
`define VWR_ONE_T     3'h1
`define VWR_ONEHALF_T 3'h2

// Extra edges when the wait-extend input is low
`define VWR_XWAIT_0 3'h1
`define VWR_XWAIT_1 3'h2

`endif

// ===== core/vwr_pkg.sv
// Types of the VRAM wait and row-strobe timing block.
// Assumes nothing beyond a SystemVerilog compiler.
package vwr_pkg;

	typedef enum logic [4:0] {
		VWR_IDLE      = 5'h01,
		VWR_GNT_WAIT  = 5'h02,
		VWR_ACCESS    = 5'h04,
		VWR_REFRESH   = 5'h08,
		VWR_PRECHARGE = 5'h10
	} vwr_state_e;

	typedef struct packed {
		logic [2:0] configMode;
		logic       handshakeType;
		logic [0:0] extraWait;
		logic [1:0] burstWait;
		logic [1:0] accessDelay;
		logic [1:0] rowTiming;
	} vwr_prog_s;

endpackage : vwr_pkg

// ===== core/vwr_sel_if.sv
// Strobe selection signals between the timing core and its decoder.
// Assumes both ends run on the same clock; the signals are combinational.
interface vwr_sel_if;
	logic [2:0] configMode;
	logic [1:0] bankSelect;
	logic [3:0] rasSel;
	logic [3:0] casSel;

	modport core (output configMode, output bankSelect,
		input rasSel, input casSel);
	modport decoder (input configMode, input bankSelect,
		output rasSel, output casSel);
endinterface : vwr_sel_if

// ===== core/vwr_strobe_decode.sv
// Row and column strobe selection from configuration mode and bank inputs.
// Assumes synchronised bank inputs and a stable programmed mode.
module vwr_strobe_decode (
	vwr_sel_if.decoder sel
);
	logic [3:0] oneHot;

	assign oneHot = 4'h1 << sel.bankSelect;

	// Each strobe serves one quarter of the array only in mode 7; mode 6 does so for row strobes only, modes 4 and 5 pair row strobes, others drive all four
	always_comb begin
		case (sel.configMode)
			3'h7: begin
				sel.rasSel = oneHot;
				sel.casSel = oneHot;
			end
			3'h6: begin
				sel.rasSel = oneHot;
				sel.casSel = 4'hF;
			end
			3'h4, 3'h5: begin
				sel.rasSel = sel.bankSelect[0] ? 4'hC : 4'h3;
				sel.casSel = 4'hF;
			end
			default: begin
				sel.rasSel = 4'hF;
				sel.casSel = 4'hF;
			end
		endcase
	end

endmodule : vwr_strobe_decode

// ===== core/vwr_timing.sv
// Wait or acknowledge generator and row-strobe timing of a VRAM controller.
// Assumes pins asynchronous to mclk; register port synchronous to mclk.
//
// Design decisions made here: the address map and the address-and-strobe port.
`include "vwr_cfg.svh"

// Operation
// - Handshake-type bit picks wait-type (0) or acknowledge-type (1) output.
// - Wait-extend low delays handshake one more edge, two if extra-wait set.
// - Burst code 0,0: handshake stays ready during the burst.
// - Burst 0,1: not-ready on enables negated; ready edge after they assert.
// - Burst 1,0: not-ready on enables negated; ready low level after assert.
// - Burst 1,1: handshake follows column enables with no added alignment.
// - Delay 0,0 wait: high on plain access; delayed, negates at RAS negate.
// - Delay 0,0 acknowledge: asserted together with the access row strobe.
// - Delay 0,1: wait half cycle after RAS; acknowledge next rising edge.
// - Delay 1,0: wait high unless delayed; else and ack low level after.
// - Delay 1,1: wait at next rising edge; ack on following low level.
// - Refresh row strobe width 2, 3, 2, 4 edges by row-timing code.
// - Precharge 1, 2, 2, 3 edges by row-timing code.
// - After grant change, RAS starts first edge (0,0 1,0) or second.
// - Column strobe low only if selected and enabled by its enable input.
// - Column strobe selection comes from configuration mode and bank inputs.
// - Modes 7 and 6 give each row strobe a quarter of the array, column strobes only in mode 7; other modes share strobes.
// - Grant output high means second port owns the array, low first port.
module vwr_timing (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [3:0]  regAddr,
	input  wire logic [15:0] regWriteData,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [15:0] regReadData,
	input  wire logic        accessRequest,
	input  wire logic        accessDelayed,
	input  wire logic        refreshRequest,
	input  wire logic        secondPortSelect,
	input  wire logic        waitExtendInN,
	input  wire logic [1:0]  columnEnableInputs,
	input  wire logic [1:0]  bankSelectInputs,
	output logic      [3:0]  rowStrobeN,
	output logic      [3:0]  columnStrobeN,
	output logic             waitOrAck,
	output logic             secondPortGrant
);
	localparam int SYNC_W = 9;

	vwr_pkg::vwr_prog_s  prog_reg;
	vwr_pkg::vwr_state_e state_reg;
	vwr_pkg::vwr_state_e state_next;
	logic [2:0]          cnt_reg;
	logic [2:0]          cnt_next;
	logic                grant_next;
	logic [SYNC_W-1:0]   syncA_reg;
	logic [SYNC_W-1:0]   syncB_reg;
	logic                reqS;
	logic                delayedS;
	logic                refreshS;
	logic                portS;
	logic                extendNS;
	logic [1:0]          colEnS;
	logic [1:0]          bankS;
	logic                colEnAny;
	logic                canStart;
	logic                startAccess;
	logic [2:0]          hsCnt_reg;
	logic                hsReady_reg;
	logic                initDone_reg;
	logic                neverReady_reg;
	logic [2:0]          hsDelay;
	logic                hsNever;
	logic [3:0]          enable4;

	vwr_sel_if sel ();

	vwr_strobe_decode uDecode (
		.sel (sel)
	);

	// Two-stage synchronisers for every pin input
	always_ff @(posedge mclk) begin
		if (srst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end else begin
			syncA_reg <= {accessRequest, accessDelayed, refreshRequest,
				secondPortSelect, waitExtendInN, columnEnableInputs,
				bankSelectInputs};
			syncB_reg <= syncA_reg;
		end
	end

	assign {reqS, delayedS, refreshS, portS, extendNS, colEnS, bankS} =
		syncB_reg;
	assign colEnAny = |colEnS;
	assign sel.configMode = prog_reg.configMode;
	assign sel.bankSelect = bankS;

	// Programming word stays until the next write
	always_ff @(posedge mclk) begin
		if (srst) begin
			prog_reg <= `VWR_PROG_RST;
		end else if (regWrite && regAddr == `VWR_OFS_PROG) begin
			prog_reg <= regWriteData[10:0];
		end
	end

	// Read data in the cycle after the read strobe only
	always_ff @(posedge mclk) begin
		if (srst) begin
			regReadData <= 16'h0000;
		end else if (regRead && regAddr == `VWR_OFS_PROG) begin
			regReadData <= {5'h00, prog_reg};
		end else if (regRead && regAddr == `VWR_OFS_STAT) begin
			regReadData <= '0;
			regReadData[`VWR_STAT_STATE +: 5] <= state_reg;
			regReadData[`VWR_STAT_READY] <= hsReady_reg;
			regReadData[`VWR_STAT_GRANT] <= secondPortGrant;
			regReadData[`VWR_STAT_INIT] <= initDone_reg;
		end else begin
			regReadData <= 16'h0000;
		end
	end

	function automatic logic [2:0] refreshWidth(input logic [1:0] code);
		case (code)
			2'h0: refreshWidth = `VWR_REFW_00;
			2'h1: refreshWidth = `VWR_REFW_01;
			2'h2: refreshWidth = `VWR_REFW_10;
			default: refreshWidth = `VWR_REFW_11;
		endcase
	endfunction : refreshWidth

	function automatic logic [2:0] prechargeTime(input logic [1:0] code);
		case (code)
			2'h0: prechargeTime = `VWR_PRE_00;
			2'h1: prechargeTime = `VWR_PRE_01;
			2'h2: prechargeTime = `VWR_PRE_10;
			default: prechargeTime = `VWR_PRE_11;
		endcase
	endfunction : prechargeTime

	function automatic logic [2:0] grantDelay(input logic [1:0] code);
		case (code)
			2'h0: grantDelay = `VWR_GNT_00;
			2'h1: grantDelay = `VWR_GNT_01;
			2'h2: grantDelay = `VWR_GNT_10;
			default: grantDelay = `VWR_GNT_11;
		endcase
	endfunction : grantDelay

	// A new cycle may begin from idle or at the end of precharge
	assign canStart = state_reg == vwr_pkg::VWR_IDLE ||
		(state_reg == vwr_pkg::VWR_PRECHARGE && cnt_reg == 3'h0);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		grant_next = secondPortGrant;
		case (state_reg)
			vwr_pkg::VWR_IDLE, vwr_pkg::VWR_PRECHARGE: begin
				if (!canStart) begin
					cnt_next = cnt_reg - 3'h1;
				end else if (refreshS) begin
					state_next = vwr_pkg::VWR_REFRESH;
					cnt_next = refreshWidth(prog_reg.rowTiming) - 3'h1;
				end else if (reqS && portS != secondPortGrant) begin
					grant_next = portS;
					state_next = vwr_pkg::VWR_GNT_WAIT;
					cnt_next = grantDelay(prog_reg.rowTiming) - 3'h1;
				end else if (reqS) begin
					state_next = vwr_pkg::VWR_ACCESS;
				end else begin
					state_next = vwr_pkg::VWR_IDLE;
				end
			end
			vwr_pkg::VWR_GNT_WAIT: begin
				if (cnt_reg == 3'h0) begin
					state_next = vwr_pkg::VWR_ACCESS;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			vwr_pkg::VWR_ACCESS: begin
				if (!reqS) begin
					state_next = vwr_pkg::VWR_PRECHARGE;
					cnt_next = prechargeTime(prog_reg.rowTiming) - 3'h1;
				end
			end
			vwr_pkg::VWR_REFRESH: begin
				if (cnt_reg == 3'h0) begin
					state_next = vwr_pkg::VWR_PRECHARGE;
					cnt_next = prechargeTime(prog_reg.rowTiming) - 3'h1;
				end else begin
					cnt_next = cnt_reg - 3'h1;
				end
			end
			default: begin
				state_next = vwr_pkg::VWR_IDLE;
				cnt_next = 3'h0;
			end
		endcase
	end

	// Precharge counts down before the next start is allowed
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= vwr_pkg::VWR_IDLE;
			cnt_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			secondPortGrant <= 1'b0;
		end else begin
			secondPortGrant <= grant_next;
		end
	end

	// Row strobes follow the state being entered
	always_ff @(posedge mclk) begin
		if (srst) begin
			rowStrobeN <= 4'hF;
		end else if (state_next == vwr_pkg::VWR_REFRESH) begin
			rowStrobeN <= 4'h0;
		end else if (state_next == vwr_pkg::VWR_ACCESS) begin
			rowStrobeN <= ~sel.rasSel;
		end else begin
			rowStrobeN <= 4'hF;
		end
	end

	// Enable 0 gates strobes 0 and 1, enable 1 gates strobes 2 and 3
	assign enable4 = {colEnS[1], colEnS[1], colEnS[0], colEnS[0]};

	always_ff @(posedge mclk) begin
		if (srst) begin
			columnStrobeN <= 4'hF;
		end else if (state_reg == vwr_pkg::VWR_ACCESS && reqS) begin
			columnStrobeN <= ~(sel.casSel & enable4);
		end else begin
			columnStrobeN <= 4'hF;
		end
	end

	assign startAccess = state_reg != vwr_pkg::VWR_ACCESS &&
		state_next == vwr_pkg::VWR_ACCESS;

	// Edges from the row-strobe edge to the first ready
	always_comb begin
		hsNever = 1'b0;
		case (prog_reg.accessDelay)
			2'h0: begin
				hsDelay = `VWR_ZERO_T;
				hsNever = !prog_reg.handshakeType && delayedS;
			end
			2'h1: begin
				hsDelay = prog_reg.handshakeType ? `VWR_ONE_T
					: `VWR_HALF_T;
			end
			2'h2: begin
				hsDelay = (prog_reg.handshakeType || delayedS) ?
					`VWR_HALF_T : `VWR_ZERO_T;
			end
			default: begin
				hsDelay = prog_reg.handshakeType ? `VWR_ONEHALF_T
					: `VWR_ONE_T;
			end
		endcase
		if (!extendNS) begin
			hsDelay = hsDelay + (prog_reg.extraWait[0] ?
				`VWR_XWAIT_1 : `VWR_XWAIT_0);
		end
	end

	// First ready after the programmed delay, then burst handling
	always_ff @(posedge mclk) begin
		if (srst) begin
			hsCnt_reg <= 3'h0;
			hsReady_reg <= 1'b0;
			initDone_reg <= 1'b0;
			neverReady_reg <= 1'b0;
		end else if (startAccess) begin
			hsCnt_reg <= hsDelay;
			neverReady_reg <= hsNever;
			hsReady_reg <= hsDelay == 3'h0 && !hsNever;
			initDone_reg <= hsDelay == 3'h0 && !hsNever;
		end else if (state_reg == vwr_pkg::VWR_ACCESS && !reqS) begin
			hsReady_reg <= neverReady_reg;
			initDone_reg <= 1'b0;
		end else if (state_reg == vwr_pkg::VWR_ACCESS && !initDone_reg) begin
			if (!neverReady_reg && hsCnt_reg != 3'h0) begin
				hsCnt_reg <= hsCnt_reg - 3'h1;
				if (hsCnt_reg == 3'h1) begin
					hsReady_reg <= 1'b1;
					initDone_reg <= 1'b1;
				end
			end
		end else if (state_reg == vwr_pkg::VWR_ACCESS) begin
			case (prog_reg.burstWait)
				2'h0: hsReady_reg <= 1'b1;
				2'h1: hsReady_reg <= colEnAny;
				2'h2: hsReady_reg <= colEnAny;
				default: hsReady_reg <= colEnAny;
			endcase
		end else if (state_reg != vwr_pkg::VWR_PRECHARGE) begin
			hsReady_reg <= 1'b0;
			neverReady_reg <= 1'b0;
		end
	end

	// Wait style: high means ready; acknowledge style: low means ready
	always_ff @(posedge mclk) begin
		if (srst) begin
			waitOrAck <= 1'b0;
		end else begin
			waitOrAck <= hsReadyNext() ^ prog_reg.handshakeType;
		end
	end

	// Ready value being registered this edge, so the pin is not a cycle late
	function automatic logic hsReadyNext();
		logic r;
		r = hsReady_reg;
		if (startAccess) begin
			r = hsDelay == 3'h0 && !hsNever;
		end else if (state_reg == vwr_pkg::VWR_ACCESS && !reqS) begin
			r = neverReady_reg;
		end else if (state_reg == vwr_pkg::VWR_ACCESS && !initDone_reg) begin
			r = !neverReady_reg && hsCnt_reg == 3'h1;
		end else if (state_reg == vwr_pkg::VWR_ACCESS) begin
			r = prog_reg.burstWait == 2'h0 || colEnAny;
		end else if (state_reg != vwr_pkg::VWR_PRECHARGE) begin
			r = 1'b0;
		end
		hsReadyNext = r;
	endfunction : hsReadyNext

endmodule : vwr_timing

// ===== tb/vwr_cpu_model.sv
// Processor-side model: raises and holds the access request, gives enables.
// Assumes start and stop pulses from the bench, synchronous to mclk.
module vwr_cpu_model
(
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       startReq,
	input  wire logic       stopReq,
	input  wire logic [1:0] enables,
	output logic            accessRequest,
	output logic [1:0]      columnEnableInputs
);
	timeunit 1ns;
	timeprecision 1ns;
	logic request_reg;

	// Request stays up for the whole access until told to drop
	always_ff @(posedge mclk) begin
		if (srst || stopReq) begin
			request_reg <= 1'b0;
		end else if (startReq) begin
			request_reg <= 1'b1;
		end
	end
	assign accessRequest = request_reg;
	assign columnEnableInputs = request_reg ? enables : 2'h0;
endmodule : vwr_cpu_model

// ===== tb/vwr_timing_bench.sv
// Self-checking bench of the VRAM wait and row-strobe timing block.
// Assumes the timing core, its bound checker and the processor model.
module vwr_timing_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWriteData = 16'h0000;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        accessDelayed = 1'b0;
	logic        refreshRequest = 1'b0;
	logic        secondPortSelect = 1'b0;
	logic        waitExtendInN = 1'b1;
	logic [1:0]  bankSelectInputs = 2'h0;
	logic        startReq = 1'b0;
	logic        stopReq = 1'b0;
	logic [1:0]  enables = 2'h1;
	logic        hs = 1'b0;
	logic [15:0] regReadData;
	logic        accessRequest;
	logic [1:0]  columnEnableInputs;
	logic [3:0]  rowStrobeN;
	logic [3:0]  columnStrobeN;
	logic        waitOrAck;
	logic        secondPortGrant;
	int          fail_count = 0;
	int          n_tests = 0;

	vwr_timing dut (.mclk, .srst, .regAddr, .regWriteData, .regWrite,
		.regRead, .regReadData, .accessRequest, .accessDelayed,
		.refreshRequest, .secondPortSelect, .waitExtendInN,
		.columnEnableInputs, .bankSelectInputs, .rowStrobeN,
		.columnStrobeN, .waitOrAck, .secondPortGrant);
	vwr_cpu_model u_cpu (.mclk, .srst, .startReq, .stopReq, .enables,
		.accessRequest, .columnEnableInputs);

	initial begin
		forever #50 mclk = ~mclk;
	end

	task automatic chk(input string nm, input logic [15:0] s,
		input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : tick

	task automatic regWr(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWriteData <= d;
		regWrite <= 1'b1;
		@(posedge mclk);
		regWrite <= 1'b0;
	endtask : regWr

	task automatic regRd(input logic [3:0] a, input logic [15:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge mclk);
		regRead <= 1'b0;
		#1;
		chk("read data", regReadData, e);
	endtask : regRd

	task automatic setProg(input logic h, input logic x, input logic [1:0] b,
		input logic [1:0] d, input logic [1:0] r, input logic [2:0] m);
		hs = h;
		regWr(4'h0, {5'h00, m, h, x, b, d, r});
	endtask : setProg

	task automatic waitRas(input logic low);
		int i;
		i = 0;
		while (((rowStrobeN !== 4'hF) !== low) && i < 40) begin
			tick(1);
			i++;
		end
	endtask : waitRas

	task automatic startAcc;
		@(posedge mclk);
		startReq <= 1'b1;
		@(posedge mclk);
		startReq <= 1'b0;
		#1;
	endtask : startAcc

	task automatic stopAcc(input logic late);
		@(posedge mclk);
		stopReq <= 1'b1;
		@(posedge mclk);
		stopReq <= 1'b0;
		#1;
		waitRas(1'b0);
		if (late) begin
			chk("late ready", waitOrAck ^ hs, 1'b1);
		end
		tick(8);
	endtask : stopAcc

	task automatic runAccess(input logic h, input logic [1:0] d,
		input logic x, input logic e, input logic dl, input int expK);
		int k;
		setProg(h, x, d, d, 2'h0, 3'h0);
		waitExtendInN <= e;
		accessDelayed <= dl;
		enables <= 2'h1;
		startAcc;
		waitRas(1'b1);
		k = 0;
		while ((waitOrAck ^ h) !== 1'b1 && k < 10) begin
			tick(1);
			k++;
		end
		chk("ready delay", 16'(k), 16'(expK));
		if (expK < 10) begin
			tick(2);
			chk("cas pair 0", columnStrobeN, 4'hC);
			@(posedge mclk);
			enables <= 2'h0;
			tick(6);
			chk("burst gap", waitOrAck ^ h, d == 2'h0);
			@(posedge mclk);
			enables <= 2'h2;
			tick(6);
			chk("burst back", waitOrAck ^ h, 1'b1);
			chk("cas pair 1", columnStrobeN, 4'h3);
		end
		stopAcc(expK == 10);
	endtask : runAccess

	task automatic runRefresh(input logic [1:0] r, input int w, input int p);
		int nw;
		int np;
		setProg(1'b0, 1'b0, 2'h0, 2'h0, r, 3'h0);
		refreshRequest <= 1'b1;
		waitRas(1'b1);
		nw = 0;
		np = 0;
		while (rowStrobeN !== 4'hF && nw < 10) begin
			tick(1);
			nw++;
		end
		while (rowStrobeN === 4'hF && np < 10) begin
			tick(1);
			np++;
		end
		@(posedge mclk);
		refreshRequest <= 1'b0;
		chk("refresh width", 16'(nw), 16'(w));
		chk("precharge", 16'(np), 16'(p));
		tick(1);
		waitRas(1'b0);
		tick(10);
	endtask : runRefresh

	task automatic runGrant(input logic [1:0] r, input logic sel, input int g);
		int n;
		setProg(1'b1, 1'b0, 2'h0, 2'h0, r, 3'h0);
		secondPortSelect <= sel;
		startAcc;
		n = 0;
		while (secondPortGrant !== sel && n < 20) begin
			tick(1);
			n++;
		end
		n = 0;
		while (rowStrobeN === 4'hF && n < 10) begin
			tick(1);
			n++;
		end
		chk("grant lead", 16'(n), 16'(g));
		chk("grant owner", secondPortGrant, sel);
		regRd(4'h4, {8'h00, 1'b1, sel, 1'b1, 5'h04});
		stopAcc(1'b0);
	endtask : runGrant

	task automatic runRegs;
		chk("reset pins", {rowStrobeN, columnStrobeN,
			waitOrAck, secondPortGrant}, 16'h03FC);
		regRd(4'h0, 16'h0000);
		regRd(4'h4, 16'h0001);
		regRd(4'h8, 16'h0000);
		regWr(4'h0, 16'hFFFF);
		regWr(4'h8, 16'h0000);
		regRd(4'h0, 16'h07FF);
	endtask : runRegs

	task automatic runBank(input logic [2:0] m, input logic [1:0] b,
		input logic [3:0] er, input logic [3:0] ec);
		setProg(1'b1, 1'b0, 2'h0, 2'h0, 2'h0, m);
		bankSelectInputs <= b;
		enables <= 2'h3;
		startAcc;
		waitRas(1'b1);
		tick(3);
		chk("bank ras", rowStrobeN, er);
		chk("bank cas", columnStrobeN, ec);
		stopAcc(1'b0);
	endtask : runBank

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		end_sim;
	end

	initial begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		tick(4);
		runRegs;
		for (int h = 0; h < 2; h++) begin
			for (int d = 0; d < 4; d++) begin
				runAccess(h[0], d[1:0], 1'b0, 1'b1, 1'b0,
					(d == 0) ? 0 : (d == 1) ? 1 : (d == 2) ? h : h + 1);
			end
		end
		runAccess(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 2);
		runAccess(1'b1, 2'h1, 1'b1, 1'b0, 1'b0, 3);
		runAccess(1'b0, 2'h0, 1'b0, 1'b1, 1'b1, 10);
		runAccess(1'b0, 2'h2, 1'b0, 1'b1, 1'b1, 1);
		runRefresh(2'h0, 2, 1);
		runRefresh(2'h1, 3, 2);
		runRefresh(2'h2, 2, 2);
		runRefresh(2'h3, 4, 3);
		runGrant(2'h0, 1'b1, 1);
		runGrant(2'h1, 1'b0, 2);
		runBank(3'h7, 2'h2, 4'hB, 4'hB);
		runBank(3'h6, 2'h1, 4'hD, 4'h0);
		runBank(3'h4, 2'h1, 4'h3, 4'h0);
		end_sim;
	end
endmodule : vwr_timing_bench

// ===== tb/vwr_timing_properties.sv
// Concurrent checks on the pins of the VRAM wait and row-strobe block.
// Assumes binding to vwr_timing; keeps its own copy of the program word.
module vwr_timing_properties (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic [3:0]  regAddr,
	input wire logic [15:0] regWriteData,
	input wire logic        regWrite,
	input wire logic [3:0]  rowStrobeN,
	input wire logic [3:0]  columnStrobeN,
	input wire logic        waitOrAck,
	input wire logic        secondPortGrant
);
	timeunit 1ns;
	timeprecision 1ns;
	vwr_pkg::vwr_prog_s prog_reg;
	logic [2:0]         lowCnt_reg;
	logic [2:0]         highCnt_reg;
	logic               casSeen_reg;
	logic               rasHigh;
	logic               ready;
	logic [2:0]         refW;
	logic [2:0]         preW;

	assign rasHigh = rowStrobeN == 4'hF;
	assign ready = waitOrAck ^ prog_reg.handshakeType;
	assign refW = (prog_reg.rowTiming == 2'h3) ? 3'h4 :
		(prog_reg.rowTiming == 2'h1) ? 3'h3 : 3'h2;
	assign preW = (prog_reg.rowTiming == 2'h0) ? 3'h1 :
		(prog_reg.rowTiming == 2'h3) ? 3'h3 : 3'h2;

	always_ff @(posedge mclk) begin
		if (srst) begin
			prog_reg <= '0;
		end else if (regWrite && regAddr == 4'h0) begin
			prog_reg <= vwr_pkg::vwr_prog_s'(regWriteData[10:0]);
		end
	end

	// Length of the current low run; a run without column strobes is refresh
	always_ff @(posedge mclk) begin
		if (srst || rasHigh) begin
			lowCnt_reg <= 3'h0;
			casSeen_reg <= 1'b0;
		end else begin
			lowCnt_reg <= lowCnt_reg + {2'h0, lowCnt_reg != 3'h7};
			casSeen_reg <= casSeen_reg | (columnStrobeN != 4'hF);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			highCnt_reg <= 3'h7;
		end else if (!rasHigh) begin
			highCnt_reg <= 3'h0;
		end else begin
			highCnt_reg <= highCnt_reg + {2'h0, highCnt_reg != 3'h7};
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	a_refresh_width: assert property (
		rasHigh && !$past(rasHigh) && !casSeen_reg |-> lowCnt_reg == refW)
		else $error("refresh row strobe width wrong");
	a_precharge_gap: assert property (
		!rasHigh && $past(rasHigh) |-> highCnt_reg >= preW)
		else $error("precharge too short");
	a_grant_one: assert property (
		$changed(secondPortGrant) && !prog_reg.rowTiming[0]
		|-> rasHigh ##1 !rasHigh)
		else $error("row strobe not one edge after grant");
	a_grant_two: assert property (
		$changed(secondPortGrant) && prog_reg.rowTiming[0]
		|-> rasHigh ##1 rasHigh ##1 !rasHigh)
		else $error("row strobe not two edges after grant");
	a_grant_quiet: assert property (
		!rasHigh |-> $stable(secondPortGrant))
		else $error("grant moved during a row strobe");
	a_cas_in_access: assert property (
		columnStrobeN != 4'hF |-> !rasHigh)
		else $error("column strobe outside an access");
	a_burst_zero: assert property (
		prog_reg.burstWait == 2'h0 && ready && !rasHigh
		|=> ready || rasHigh)
		else $error("burst wait added with burst code zero");
	a_idle_level: assert property (
		highCnt_reg == 3'h7 && rasHigh && prog_reg == $past(prog_reg, 2)
		|-> waitOrAck == prog_reg.handshakeType)
		else $error("idle handshake level wrong");
endmodule : vwr_timing_properties

bind vwr_timing vwr_timing_properties u_props (.mclk, .srst, .regAddr,
	.regWriteData, .regWrite, .rowStrobeN, .columnStrobeN, .waitOrAck,
	.secondPortGrant);
